// ---- hw/pertim_defs.svh ----
// Purpose: constants of the periodic timer (offsets, fields, codes, reset values)
// Assumes: 32-bit classic wishbone slave, byte address, word-aligned registers
// Notes: included by bare name; definitions only
`ifndef PERTIM_DEFS_SVH
`define PERTIM_DEFS_SVH

// ==========================================================================
// widths and register offsets
`define PT_CNT_W 10
`define PT_PRE_W 8
`define PT_OFF_CTRL 8'h00
`define PT_OFF_FLAG 8'h04
`define PT_OFF_CNT 8'h08
`define PT_OFF_COMPARE_A_VALUE 8'h0C
`define PT_OFF_COMPARE_B_VALUE 8'h10
`define PT_OFF_PERIOD_VALUE 8'h14
`define PT_OFF_DIV 8'h18

// ==========================================================================
// control and flag register fields
`define PT_C_RUN 0
`define PT_C_MODE 2:1
`define PT_C_IO 4:3
`define PT_C_OC 5
`define PT_C_POL 6
`define PT_C_CAPTS 7
`define PT_C_CCLR 8
`define PT_C_TCLR 10:9
`define PT_C_VLF 11
`define PT_F_A 0
`define PT_F_P 1
`define PT_F_CAP 2

// ==========================================================================
// output action and capture codes, reset values
`define PT_IO_NONE 2'h0
`define PT_IO_LOW 2'h1
`define PT_IO_HIGH 2'h2
`define PT_IO_TOG 2'h3
`define PT_TC_NONE 2'h0
`define PT_DIV_RST 8'h01
`define PT_DIV_MIN 8'h01

`endif

// ---- hw/pertim_pkg.sv ----
// Purpose: shared types of the periodic timer
// Assumes: enum order gives the mode field encoding 00..11
// Notes: numeric constants live in pertim_defs.svh
package pertim_pkg;
    typedef enum logic [1:0] {
        PT_CMP,
        PT_CAP,
        PT_PWM,
        PT_TC
    } pertim_mode_e;
endpackage

// ---- hw/pertim_timer.sv ----
// Purpose: periodic timer with compare, pwm, single pulse and capture modes
// Assumes: pins synchronous to sys_clk; wishbone classic slave, one wait state
// Notes: no interrupt output; events are sticky write-one-to-clear flags
`timescale 1ns/1ps
`include "pertim_defs.svh"

module pertim_timer
    import pertim_pkg::*;
#(
    parameter int CW = `PT_CNT_W,
    parameter int PW = `PT_PRE_W
) (
    input wire logic sys_clk, // system clock, 100 MHz
    input wire logic rst, // async reset, active high
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write enable
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic clock_trigger_pin, // trigger / alternate capture pin
    input wire logic capture_input_pin, // dedicated capture pin
    output logic timer_out, // timer output level
    output logic timer_out_oe // high while the block drives the pin
);

    // ======================================================================
    // parameter check
    if (CW < 2 || CW > 16 || PW < 2 || PW > 16) begin : g_chk
        $error("pertim_timer: unsupported width parameters");
    end

    // ======================================================================
    // state
    logic run_q, run_prev_q, oc_q, pol_q, capts_q, cclr_q, vlf_q;
    logic fa_q, fp_q, fc_q, lvl_q, trig_prev_q, cap_prev_q;
    logic tick_q, ack_q, out_q, oe_q;
    pertim_mode_e mode_q;
    logic [1:0] io_q, tclr_q;
    logic [CW-1:0] cnt_q, compare_a_value_q, compare_b_value_q, period_value_q, cnt_inc;
    logic [PW-1:0] div_q, pre_q, div_eff;
    logic [31:0] rdat_d, ctrl_rd, msk;
    logic [31:0] ctl_m, ca_m, cb_m, cp_m, dv_m;
    logic req, wr, run_rise, sp, is_cmp, hit_a, hit_p, clr;
    logic src, src_prev, rise, fall, cap_hit, cap_to_b, lvl_d, out_d;

    // ======================================================================
    // bus decode; byte lanes form a write mask
    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    // a write lands at the edge where the master samples ack high
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
    assign msk = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign ctrl_rd = {20'h0, vlf_q, tclr_q, cclr_q, capts_q, pol_q, oc_q, io_q,
                      mode_q, run_q};

    // merge write data into an old register image under the lane mask
    function automatic logic [31:0] merge(input logic [31:0] old);
        merge = (old & ~msk) | (wb_dat_i & msk);
    endfunction

    // merged images per register, so that fields are plain part-selects
    assign ctl_m = merge(ctrl_rd);
    assign ca_m = merge(32'(compare_a_value_q));
    assign cb_m = merge(32'(compare_b_value_q));
    assign cp_m = merge(32'(period_value_q));
    assign dv_m = merge(32'(div_q));

    // ======================================================================
    // timer tick divider; a floor on the divisor keeps the tick at or
    // below half of sys_clk, which the a_tick_rate assertion checks
    assign div_eff = (div_q < PW'(`PT_DIV_MIN)) ? PW'(`PT_DIV_MIN) : div_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pre_q <= '0;
            tick_q <= 1'b0;
        end else if (pre_q >= div_eff) begin
            pre_q <= '0;
            tick_q <= 1'b1;
        end else begin
            pre_q <= pre_q + PW'(1);
            tick_q <= 1'b0;
        end
    end

    // ======================================================================
    // match and edge detection
    assign cnt_inc = cnt_q + CW'(1);
    assign sp = (mode_q == PT_PWM) && (io_q == `PT_IO_TOG);
    assign is_cmp = (mode_q == PT_CMP) || (mode_q == PT_TC);
    assign run_rise = run_q & ~run_prev_q;
    // a zero A value never matches, so with A as clear source the counter simply wraps at all ones
    // the start cycle still holds a stale count, so it must never match
    assign hit_a = tick_q & run_q & ~run_rise & (cnt_inc == compare_a_value_q) & (compare_a_value_q != '0);
    // a zero period matches on the wrap, giving the overflow clear
    assign hit_p = tick_q & run_q & ~run_rise & (cnt_inc == period_value_q);
    assign src = capts_q ? clock_trigger_pin : capture_input_pin;
    assign src_prev = capts_q ? trig_prev_q : cap_prev_q;
    assign rise = src & ~src_prev;
    assign fall = ~src & src_prev;

    // capture qualifier: edge select 11 captures nothing
    always_comb begin
        cap_hit = 1'b0;
        if (mode_q == PT_CAP && run_q) begin
            case (io_q)
                2'h0: cap_hit = rise;
                2'h1: cap_hit = fall;
                2'h2: cap_hit = rise | fall;
                default: cap_hit = 1'b0;
            endcase
        end
    end
    assign cap_to_b = (tclr_q != `PT_TC_NONE) & rise;

    // counter clear source per mode
    always_comb begin
        case (mode_q)
            PT_CMP, PT_TC: clr = cclr_q ? hit_a : hit_p;
            PT_PWM: clr = ~sp & hit_p;
            PT_CAP: begin
                clr = hit_p;
                if (run_q) begin
                    case (tclr_q)
                        2'h1: clr = hit_p | rise;
                        2'h2: clr = hit_p | fall;
                        2'h3: clr = hit_p | rise | fall;
                        default: clr = hit_p;
                    endcase
                end
            end
            default: clr = 1'b0;
        endcase
    end

    // ======================================================================
    // counter: restarts at zero on a run rising edge, holds while stopped
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (run_rise) begin
            cnt_q <= '0;
        end else if (clr) begin
            cnt_q <= '0;
        end else if (run_q && tick_q) begin
            cnt_q <= cnt_inc;
        end
    end

    // pin history for edge detection
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            trig_prev_q <= 1'b0;
            cap_prev_q <= 1'b0;
            run_prev_q <= 1'b0;
        end else begin
            trig_prev_q <= clock_trigger_pin;
            cap_prev_q <= capture_input_pin;
            run_prev_q <= run_q;
        end
    end

    // ======================================================================
    // control register; hardware start and stop override a same-cycle write
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            run_q <= 1'b0;
            mode_q <= PT_CMP;
            io_q <= `PT_IO_NONE;
            oc_q <= 1'b0;
            pol_q <= 1'b0;
            capts_q <= 1'b0;
            cclr_q <= 1'b0;
            tclr_q <= `PT_TC_NONE;
        end else begin
            if (wr && wb_adr_i == `PT_OFF_CTRL) begin
                run_q <= ctl_m[`PT_C_RUN];
                mode_q <= pertim_mode_e'(ctl_m[`PT_C_MODE]);
                io_q <= ctl_m[`PT_C_IO];
                oc_q <= ctl_m[`PT_C_OC];
                pol_q <= ctl_m[`PT_C_POL];
                capts_q <= ctl_m[`PT_C_CAPTS];
                cclr_q <= ctl_m[`PT_C_CCLR];
                tclr_q <= ctl_m[`PT_C_TCLR];
            end
            if (sp && !run_q && clock_trigger_pin && !trig_prev_q) begin
                run_q <= 1'b1;
            end
            if (sp && hit_a) begin
                run_q <= 1'b0;
            end
        end
    end

    // ======================================================================
    // sticky event flags: write one to clear, a same-cycle event wins
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fa_q <= 1'b0;
            fp_q <= 1'b0;
            fc_q <= 1'b0;
        end else begin
            if (wr && wb_adr_i == `PT_OFF_FLAG) begin
                fa_q <= fa_q & ~(wb_sel_i[0] & wb_dat_i[`PT_F_A]);
                fp_q <= fp_q & ~(wb_sel_i[0] & wb_dat_i[`PT_F_P]);
                fc_q <= fc_q & ~(wb_sel_i[0] & wb_dat_i[`PT_F_CAP]);
            end
            if (hit_a && mode_q != PT_CAP) begin
                fa_q <= 1'b1;
            end
            if (hit_p && !(is_cmp && cclr_q) && !sp) begin
                fp_q <= 1'b1;
            end
            if (cap_hit) begin
                fc_q <= 1'b1;
            end
        end
    end

    // ======================================================================
    // compare and period values; a capture overrides a same-cycle write
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            compare_a_value_q <= '0;
            compare_b_value_q <= '0;
            period_value_q <= '0;
            vlf_q <= 1'b0;
        end else begin
            if (wr && wb_adr_i == `PT_OFF_COMPARE_A_VALUE) begin
                compare_a_value_q <= ca_m[CW-1:0];
            end
            if (wr && wb_adr_i == `PT_OFF_COMPARE_B_VALUE) begin
                compare_b_value_q <= cb_m[CW-1:0];
            end
            if (wr && wb_adr_i == `PT_OFF_PERIOD_VALUE) begin
                period_value_q <= cp_m[CW-1:0];
            end
            if (cap_hit) begin
                vlf_q <= rise;
                if (cap_to_b) begin
                    compare_b_value_q <= cnt_q;
                end else begin
                    compare_a_value_q <= cnt_q;
                end
            end
        end
    end

    // tick divisor
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_q <= PW'(`PT_DIV_RST);
        end else if (wr && wb_adr_i == `PT_OFF_DIV) begin
            div_q <= dv_m[PW-1:0];
        end
    end

    // ======================================================================
    // compare-mode output level
    always_comb begin
        lvl_d = lvl_q;
        if (run_rise) begin
            lvl_d = oc_q;
        end else if (hit_a && mode_q == PT_CMP) begin
            case (io_q)
                `PT_IO_LOW: lvl_d = 1'b0;
                `PT_IO_HIGH: lvl_d = 1'b1;
                `PT_IO_TOG: lvl_d = ~lvl_q;
                default: lvl_d = lvl_q;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lvl_q <= 1'b0;
        end else begin
            lvl_q <= lvl_d;
        end
    end

    // pin value per mode; the pwm compare runs under every action code but 11 (single pulse),
    // so forcing the pin never disturbs the period
    always_comb begin
        out_d = 1'b0;
        case (mode_q)
            PT_CMP: out_d = lvl_q ^ pol_q;
            PT_PWM: begin
                if (sp) begin
                    out_d = (run_q ? oc_q : ~oc_q) ^ pol_q;
                end else begin
                    case (io_q)
                        `PT_IO_NONE: out_d = ~oc_q ^ pol_q;
                        `PT_IO_LOW: out_d = oc_q ^ pol_q;
                        default: out_d = ((cnt_q < compare_a_value_q) ? oc_q : ~oc_q) ^ pol_q;
                    endcase
                end
            end
            default: out_d = 1'b0;
        endcase
    end

    // registered pin outputs; counter and capture modes release the pin
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            out_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            out_q <= out_d;
            oe_q <= (mode_q == PT_CMP) || (mode_q == PT_PWM);
        end
    end

    assign timer_out = out_q;
    assign timer_out_oe = oe_q;

    // ======================================================================
    // read mux; unmapped addresses read zero
    always_comb begin
        case (wb_adr_i)
            `PT_OFF_CTRL: rdat_d = ctrl_rd;
            `PT_OFF_FLAG: rdat_d = {29'h0, fc_q, fp_q, fa_q};
            `PT_OFF_CNT: rdat_d = 32'(cnt_q);
            `PT_OFF_COMPARE_A_VALUE: rdat_d = 32'(compare_a_value_q);
            `PT_OFF_COMPARE_B_VALUE: rdat_d = 32'(compare_b_value_q);
            `PT_OFF_PERIOD_VALUE: rdat_d = 32'(period_value_q);
            `PT_OFF_DIV: rdat_d = 32'(div_q);
            default: rdat_d = 32'h0;
        endcase
    end

    // one-cycle acknowledge, dropped in the following cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            ack_q <= req;
            if (req) begin
                wb_dat_o <= rdat_d;
            end
        end
    end

    assign wb_ack_o = ack_q;

    // ======================================================================
    // assertions and covers
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_cmp_p_clear: assert property (is_cmp && !cclr_q && hit_p && !run_rise |=> cnt_q == '0)
        else $error("period match did not clear counter");
    a_no_p_flag: assert property (is_cmp && cclr_q && !fp_q |=> !fp_q)
        else $error("period flag set with clear-select high");
    a_zero_a_flag: assert property (is_cmp && compare_a_value_q == '0 && !fa_q |=> !fa_q)
        else $error("A flag set with A value zero");
    a_out_stable: assert property (mode_q == PT_CMP && !hit_a && !run_rise |=> $stable(lvl_q))
        else $error("compare output moved without A match");
    a_start_level: assert property (mode_q == PT_CMP && run_rise |=> lvl_q == $past(oc_q))
        else $error("run rise did not load initial level");
    a_tc_release: assert property (mode_q == PT_TC |=> !timer_out_oe)
        else $error("pin driven in timer/counter mode");
    a_pwm_active: assert property (mode_q == PT_PWM && io_q == `PT_IO_HIGH && compare_a_value_q > cnt_q
        |=> timer_out == ($past(oc_q) ^ $past(pol_q)))
        else $error("pwm output not active below duty");
    a_sp_stop: assert property (sp && hit_a |=> !run_q ##1
        (!timer_out_oe || timer_out == (~$past(oc_q, 2) ^ $past(pol_q, 2))))
        else $error("single pulse did not end on A match");
    a_cap_latch: assert property (cap_hit && !cap_to_b |=> compare_a_value_q == $past(cnt_q))
        else $error("capture not latched into A");
    a_edge_flag: assert property (cap_hit |=> vlf_q == $past(rise))
        else $error("latch-edge flag wrong");
    a_tick_rate: assert property (tick_q |=> !tick_q)
        else $error("timer tick above half system clock");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    c_pwm_period: cover property (mode_q == PT_PWM && !sp && hit_p);
    c_sp_end: cover property (sp && hit_a);
    c_cap_b: cover property (cap_hit && cap_to_b);

endmodule // pertim_timer

// ---- verif/pertim_pin_model.sv ----
// Purpose: far-side model of the timer pins: trigger, capture source and output load
// Assumes: pins are synchronous to sys_clk and change just after a rising edge
// Notes: the load only counts levels while the timer really drives its pin
`timescale 1ns/1ps

module pertim_pin_model (
    input wire logic sys_clk, // system clock
    input wire logic timer_out, // level seen on the timer pin
    input wire logic timer_out_oe, // high while the timer drives the pin
    output logic trig_pin, // clock/trigger pin drive
    output logic cap_pin // dedicated capture pin drive
);
    // ======================================================================
    // pin drive
    // both pins idle low from time zero
    initial begin
        trig_pin = 1'b0;
        cap_pin = 1'b0;
    end

    // a level is held for whole cycles so narrow glitches never reach the timer
    task automatic set_pin(input logic sel, input logic lvl, input int hold);
        @(posedge sys_clk);
        if (sel) begin
            trig_pin <= lvl; // trigger edge
        end else begin
            cap_pin <= lvl;
        end
        repeat (hold) @(posedge sys_clk); // callers hold from zero up to 40 cycles
    endtask

    // ======================================================================
    // output load
    // an undriven pin counts as low, as a pull-down on the board would make it
    task automatic count_high(input int n, output int hi);
        hi = 0;
        repeat (n) begin
            @(posedge sys_clk);
            if (timer_out_oe === 1'b1 && timer_out === 1'b1) begin
                hi++;
            end
        end
    endtask
endmodule // pertim_pin_model

// ---- verif/pertim_timer_tb.sv ----
// Purpose: self-checking bench of the periodic timer over wishbone and its pins
// Assumes: divisor 1 gives one timer tick every two sys_clk cycles
// Notes: read results are checked by a monitor against a queue of notes
`timescale 1ns/1ps

module pertim_timer_tb;
    import pertim_pkg::*;
    typedef struct {logic [31:0] val; logic [31:0] msk; string what;} pertim_note_s;
    localparam logic [7:0] A_CTL = 8'h00, A_FLG = 8'h04, A_CNT = 8'h08, A_CPA = 8'h0C;
    localparam logic [7:0] A_CPB = 8'h10, A_PER = 8'h14, A_DIV = 8'h18, A_NONE = 8'h1C;
    localparam logic [6:0] OC = 7'h01, POL = 7'h02, CAPTS = 7'h04, CCLR = 7'h08, TRISE = 7'h10;
    logic sys_clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, d, e;
    logic wb_ack_o, trig, cap, timer_out, timer_out_oe;
    int failures = 0, compares = 0, hi, a;
    pertim_note_s exp_q[$];

    // ======================================================================
    // clock, design and pin partner
    always #5 sys_clk = ~sys_clk;
    pertim_timer DUT (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .clock_trigger_pin(trig),
        .capture_input_pin(cap), .timer_out(timer_out), .timer_out_oe(timer_out_oe));
    pertim_pin_model pins (.sys_clk(sys_clk), .timer_out(timer_out),
        .timer_out_oe(timer_out_oe), .trig_pin(trig), .cap_pin(cap));

    // ======================================================================
    // helpers
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // one classic cycle; the request stands until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
        output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hF;
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1 && n < 20) begin
            n++;
            @(posedge sys_clk);
        end
        if (n >= 20) begin
            check("bus ack", 1, 0);
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] x;
        wb(1'b1, adr, dat, x);
    endtask

    // a mask of zero only keeps the notes in step with the reads
    task automatic rd(input logic [7:0] adr, input logic [31:0] ex, input logic [31:0] m,
        input string what, output logic [31:0] x);
        exp_q.push_back('{ex, m, what});
        wb(1'b0, adr, 32'h0, x);
    endtask

    function automatic logic [31:0] cw(input logic run, input logic [1:0] md,
        input logic [1:0] io, input logic [6:0] opt);
        return {20'h0, opt, io, md, run};
    endfunction

    // ======================================================================
    // monitor: every read answer is compared with the oldest note
    always @(posedge sys_clk) begin
        pertim_note_s nt;
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
            nt = exp_q.pop_front();
            check(nt.what, nt.val, wb_dat_o & nt.msk);
        end
    end

    // watchdog: the tests need about 6000 cycles
    initial begin
        repeat (40000) @(posedge sys_clk);
        check("watchdog", 1, 0);
        test_done();
    end

    // ======================================================================
    // main sequence
    initial begin
        a = $urandom(32'hED95);
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(A_CTL, 0, 32'hFFF, "ctl reset", d);
        rd(A_FLG, 0, 32'h7, "flag reset", d);
        rd(A_DIV, 1, 32'hFF, "divisor reset", d);
        rd(A_NONE, 0, 32'hFFFFFFFF, "unmapped", d);
        wr(A_CNT, 32'h55);
        rd(A_CNT, 0, 32'h3FF, "count read-only", d);
        e = $urandom() & 32'h3FF;
        wr(A_CPB, e);
        rd(A_CPB, e, 32'h3FF, "compare b", d);
        // compare mode, A match sets output high
        wr(A_PER, 5);
        wr(A_CPA, 3);
        wr(A_CTL, cw(1, PT_CMP, 2'h2, 0));
        repeat (3) @(posedge sys_clk);
        check("initial level", 0, timer_out);
        repeat (30) @(posedge sys_clk);
        check("set on match", 1, timer_out);
        rd(A_FLG, 3, 3, "cmp flags", d);
        rd(A_CNT, 0, 0, "cmp count", d);
        check("count below period", 1, d < 5);
        wr(A_CTL, cw(0, PT_CMP, 2'h2, 0));
        rd(A_CNT, 0, 0, "held count", e);
        repeat (10) @(posedge sys_clk);
        rd(A_CNT, e, 32'h3FF, "count holds", d);
        wr(A_CTL, cw(1, PT_CMP, 2'h2, 0));
        repeat (3) @(posedge sys_clk);
        check("restart level", 0, timer_out);
        // timer/counter mode cleared by A match
        wr(A_CTL, 0);
        wr(A_FLG, 7);
        wr(A_PER, 2);
        wr(A_CPA, 4);
        wr(A_CTL, cw(1, PT_TC, 2'h3, CCLR));
        repeat (40) @(posedge sys_clk);
        rd(A_FLG, 1, 3, "only A flag", d);
        rd(A_CNT, 0, 0, "tc count", d);
        check("count below A", 1, d < 4);
        check("pin released", 0, timer_out_oe);
        // A zero, period zero: overflow at 3FF
        wr(A_CTL, 0);
        wr(A_FLG, 7);
        wr(A_PER, 0);
        wr(A_CPA, 0);
        wr(A_CTL, cw(1, PT_CMP, 2'h3, 0));
        repeat (2200) @(posedge sys_clk);
        rd(A_FLG, 2, 3, "overflow flags", d);
        // pwm, period 8, random duty, clear select ignored
        a = 1 + ($urandom() % 7);
        wr(A_CTL, 0);
        wr(A_PER, 8);
        wr(A_CPA, a);
        wr(A_CTL, cw(1, PT_PWM, 2'h2, OC | CCLR)); // pwm selection
        repeat (20) @(posedge sys_clk);
        pins.count_high(160, hi);
        check("pwm duty", a * 20, hi);
        wr(A_CTL, cw(1, PT_PWM, 2'h2, OC | POL));
        repeat (20) @(posedge sys_clk);
        pins.count_high(160, hi);
        check("pwm inverted", 160 - a * 20, hi);
        wr(A_CTL, cw(1, PT_PWM, 2'h2, OC));
        wr(A_CPA, 9);
        repeat (20) @(posedge sys_clk);
        pins.count_high(160, hi);
        check("full duty", 160, hi);
        wr(A_CPA, a);
        for (int io = 0; io < 2; io++) begin
            wr(A_CTL, 0);
            wr(A_FLG, 7);
            wr(A_CTL, cw(1, PT_PWM, io[1:0], OC));
            repeat (20) @(posedge sys_clk);
            pins.count_high(160, hi);
            check("forced level", io * 160, hi);
            rd(A_FLG, 3, 3, "pwm flags", d);
        end
        wr(A_CTL, 0);
        wr(A_PER, 0);
        wr(A_CPA, 512);
        wr(A_CTL, cw(1, PT_PWM, 2'h2, OC));
        repeat (20) @(posedge sys_clk);
        pins.count_high(2048, hi);
        check("period 1024", 1024, hi);
        // single pulse started by the trigger pin, then by software
        wr(A_CTL, 0);
        wr(A_FLG, 7);
        wr(A_CPA, 5);
        wr(A_CTL, cw(0, PT_PWM, 2'h3, OC)); // single pulse selection
        for (int k = 0; k < 2; k++) begin
            if (k == 0) begin
                pins.set_pin(1'b1, 1'b1, 0);
            end else begin
                wr(A_CTL, cw(1, PT_PWM, 2'h3, OC));
            end
            pins.count_high(100, hi);
            check("pulse width", 1, hi >= 8 && hi <= 12);
            rd(A_CTL, 0, 1, "run cleared", d);
            rd(A_FLG, 1, 1, "pulse flag", d);
            pins.set_pin(1'b1, 1'b0, 4);
            wr(A_FLG, 7);
        end
        // capture, rising edges clear and go to B
        wr(A_CTL, 0);
        wr(A_PER, 0);
        wr(A_CPA, 0);
        wr(A_CPB, 0);
        wr(A_FLG, 7);
        wr(A_CTL, cw(1, PT_CAP, 2'h0, TRISE));
        pins.set_pin(1'b0, 1'b1, 6);
        pins.set_pin(1'b0, 1'b0, 40);
        pins.set_pin(1'b0, 1'b1, 6);
        rd(A_CPB, 0, 0, "capture b", d);
        check("rise interval", 1, d >= 21 && d <= 25);
        rd(A_CPA, 0, 32'h3FF, "a untouched", d);
        rd(A_FLG, 4, 4, "capture flag", d);
        rd(A_CTL, 32'h800, 32'h800, "rise latch", d);
        wr(A_CTL, cw(1, PT_CAP, 2'h1, TRISE));
        pins.set_pin(1'b0, 1'b0, 6);
        rd(A_CTL, 0, 32'h800, "fall latch", d);
        rd(A_CPA, 0, 0, "capture a", d);
        check("fall into A", 1, d != 0);
        // capture source select, then edge select 11
        wr(A_CTL, cw(1, PT_CAP, 2'h2, CAPTS));
        wr(A_FLG, 7);
        pins.set_pin(1'b0, 1'b1, 6);
        rd(A_FLG, 0, 4, "capture pin ignored", d);
        pins.set_pin(1'b1, 1'b1, 6);
        rd(A_FLG, 4, 4, "trigger pin capture", d);
        wr(A_CTL, cw(1, PT_CAP, 2'h3, CAPTS));
        wr(A_FLG, 7);
        pins.set_pin(1'b1, 1'b0, 6);
        rd(A_FLG, 0, 4, "capture off", d);
        rd(A_CNT, 0, 0, "count a", e);
        rd(A_CNT, 0, 0, "count b", d);
        check("count runs", 1, d != e);
        wr(A_CTL, 0);
        wr(A_PER, 10);
        wr(A_CTL, cw(1, PT_CAP, 2'h3, CAPTS)); // restart keeps the count below the period
        wr(A_FLG, 7);
        repeat (40) @(posedge sys_clk);
        rd(A_FLG, 2, 2, "capture period", d);
        // both edges clear the count; the rising edge latches into B
        wr(A_CTL, cw(1, PT_CAP, 2'h2, 7'h30));
        pins.set_pin(1'b0, 1'b0, 6);
        pins.set_pin(1'b0, 1'b1, 6);
        rd(A_CPB, 0, 0, "both edges b", d);
        check("fall clears", 1, d >= 2 && d <= 4);
        test_done();
    end
endmodule // pertim_timer_tb
